// ===== hw/eqrc_map.svh
`ifndef EQRC_MAP_SVH
`define EQRC_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define EQRC_REG_ADAPT_CTRL 8'h00
`define EQRC_REG_BOOST_OVR 8'h01
`define EQRC_REG_BYPASS_CTRL 8'h02
`define EQRC_REG_STATUS 8'h03
`define EQRC_REG_BOOST_NOW 8'h04
`define EQRC_REG_EYE_CTRL 8'h10
`define EQRC_REG_EYE_PHASE 8'h11
`define EQRC_REG_EYE_VOLT 8'h12
`define EQRC_REG_EYE_CNT_LO 8'h13
`define EQRC_REG_EYE_CNT_HI 8'h14
`define EQRC_REG_HOPEN 8'h15
`define EQRC_REG_VOPEN 8'h16
`define EQRC_REG_EYE_STAT 8'h17
`define EQRC_REG_PRESET_FIRST 8'h40
`define EQRC_REG_PRESET_LAST 8'h4f

// ****************************************
// Field positions
// ****************************************
`define EQRC_ADAPT_OVR_EN 0
`define EQRC_ADAPT_OVR_AUTO 1
`define EQRC_BOOST_OVR_EN 2
`define EQRC_BYP_OVR_EN 0
`define EQRC_BYP_OVR_LINE 1
`define EQRC_BYP_OVR_RECLK 2
`define EQRC_EYE_START 0
`define EQRC_EYE_STOP 1

// ****************************************
// Reset values and boosts
// ****************************************
`define EQRC_PRESET_RST 8'h00
`define EQRC_BOOST_H 8'h00
`define EQRC_BOOST_F 8'h00
`define EQRC_BOOST_R 8'h80
`define EQRC_BOOST_L 8'h90
`define EQRC_UNMAPPED 8'h00

// ****************************************
// Detected rate codes
// ****************************************
`define EQRC_RATE_NONE 3'h0
`define EQRC_RATE_12G 3'h1
`define EQRC_RATE_6G 3'h2
`define EQRC_RATE_3G 3'h3
`define EQRC_RATE_1G5 3'h4
`define EQRC_RATE_270M 3'h5
`define EQRC_RATE_125M 3'h6

// ****************************************
// Timing
// ****************************************
`define EQRC_CLK_MHZ 250
`define EQRC_CDR_RST_NS 64

`endif

// ===== hw/eqrc_pkg.sv
package eqrc_pkg;

	typedef enum logic [1:0] {LVL_L = 2'h0, LVL_R = 2'h1, LVL_F = 2'h2, LVL_H = 2'h3} eqrc_lvl_t;

	typedef struct packed {
		logic auto_mode;
		logic [7:0] boost;
	} eqrc_adapt_t;

	typedef struct packed {
		logic line_eq_en;
		logic host_eq_en;
		logic reclk_en;
	} eqrc_path_t;

	typedef enum {EYE_IDLE, EYE_CLEAR, EYE_RUN} eqrc_eye_st_t;

endpackage

// ===== hw/eqrc_strap_dec.sv
`timescale 1ns/1ps
`include "eqrc_map.svh"

module eqrc_strap_dec #(
	parameter int N = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Raw pad comparator codes
	input wire logic [2*N-1:0] pad_code,
	// Decoded levels
	output eqrc_pkg::eqrc_lvl_t [N-1:0] level
);

	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_strap
			logic [1:0] s1_ff;
			logic [1:0] s2_ff;
			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					s1_ff <= 2'h2;
					s2_ff <= 2'h2;
				end
				else
				begin
					s1_ff <= pad_code[2*i +: 2];
					s2_ff <= s1_ff;
				end
			end
			assign level[i] = eqrc_pkg::eqrc_lvl_t'(s2_ff);
		end
	endgenerate

endmodule

// ===== hw/eqrc_ctrl.sv
`timescale 1ns/1ps
`include "eqrc_map.svh"

module eqrc_ctrl #(
	parameter int PRESETS = 16,
	parameter int STEPS = 64,
	parameter int CNT_W = 16
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Pins
	input wire logic MODE_SELECT_PIN,
	input wire logic [1:0] HOST_BOOST_STRAP,
	input wire logic [1:0] BYPASS_STRAP,
	// Recovered rate from the loop
	input wire logic [2:0] RATE_CODE,
	input wire logic RATE_FRAC,
	// Adaptation engine preset lookup
	input wire logic [3:0] PRESET_IDX,
	output logic [7:0] PRESET_VAL,
	// Eye sampler
	input wire logic EYE_HIT,
	input wire logic [5:0] EYE_PHASE,
	input wire logic [5:0] EYE_VOLT,
	input wire logic EYE_DONE,
	input wire logic [7:0] EYE_HOPEN,
	input wire logic [7:0] EYE_VOPEN,
	// Register port
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	output logic REG_RVALID,
	// Path control
	output logic LINE_EQ_EN,
	output logic HOST_EQ_EN,
	output logic RECLK_EN,
	output logic ADAPT_AUTO,
	output logic [7:0] BOOST,
	output logic CDR_RESET,
	output logic EYE_EN
);

	localparam int CDR_RST_CYC = (`EQRC_CDR_RST_NS * `EQRC_CLK_MHZ + 999) / 1000;
	localparam int DEPTH = STEPS * STEPS;
	localparam int AW = $clog2(DEPTH);

	// ****************************************
	// Input synchronisers
	// ****************************************
	eqrc_pkg::eqrc_lvl_t [1:0] strap_lvl;
	logic mode1_ff, mode2_ff, mode_prev_ff;
	logic [3:0] rate1_ff, rate2_ff;

	eqrc_strap_dec #(.N(2)) u_strap (
		.clk(CLK),
		.rst_n(RST_N),
		.pad_code({BYPASS_STRAP, HOST_BOOST_STRAP}),
		.level(strap_lvl)
	);

	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			mode1_ff <= 1'b0;
			mode2_ff <= 1'b0;
			mode_prev_ff <= 1'b0;
			rate1_ff <= 4'h0;
			rate2_ff <= 4'h0;
		end
		else
		begin
			mode1_ff <= MODE_SELECT_PIN;
			mode2_ff <= mode1_ff;
			mode_prev_ff <= mode2_ff;
			rate1_ff <= {RATE_FRAC, RATE_CODE};
			rate2_ff <= rate1_ff;
		end
	end

	wire cd_mode = mode2_ff;
	wire eqrc_pkg::eqrc_lvl_t host_lvl = strap_lvl[0];
	wire eqrc_pkg::eqrc_lvl_t byp_lvl = strap_lvl[1];
	wire [2:0] rate = rate2_ff[2:0];
	wire frac = rate2_ff[3];

	// ****************************************
	// Registers
	// ****************************************
	logic [2:0] adapt_ctrl_ff;
	logic [7:0] boost_ovr_ff;
	logic [2:0] byp_ctrl_ff;
	logic [5:0] eye_phase_ff, eye_volt_ff;
	logic [7:0] hopen_ff, vopen_ff;
	logic [7:0] preset_ff [0:PRESETS-1];

	wire preset_hit = REG_ADDR >= `EQRC_REG_PRESET_FIRST && REG_ADDR <= `EQRC_REG_PRESET_LAST;
	wire [3:0] preset_wi = REG_ADDR[3:0];
	wire eye_start = REG_WR && REG_ADDR == `EQRC_REG_EYE_CTRL && REG_WDATA[`EQRC_EYE_START];
	wire eye_stop = REG_WR && REG_ADDR == `EQRC_REG_EYE_CTRL && REG_WDATA[`EQRC_EYE_STOP];

	genvar p;
	generate
		for (p = 0; p < PRESETS; p++)
		begin : g_preset
			always_ff @(posedge CLK)
			begin
				if (!RST_N)
					preset_ff[p] <= `EQRC_PRESET_RST;
				else if (REG_WR && preset_hit && preset_wi == 4'(p))
					preset_ff[p] <= REG_WDATA;
			end
		end
	endgenerate

	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			adapt_ctrl_ff <= 3'h0;
			boost_ovr_ff <= 8'h00;
			byp_ctrl_ff <= 3'h0;
			eye_phase_ff <= 6'h00;
			eye_volt_ff <= 6'h00;
		end
		else if (REG_WR)
		begin
			if (REG_ADDR == `EQRC_REG_ADAPT_CTRL)
				adapt_ctrl_ff <= REG_WDATA[2:0];
			if (REG_ADDR == `EQRC_REG_BOOST_OVR)
				boost_ovr_ff <= REG_WDATA;
			if (REG_ADDR == `EQRC_REG_BYPASS_CTRL)
				byp_ctrl_ff <= REG_WDATA[2:0];
			if (REG_ADDR == `EQRC_REG_EYE_PHASE)
				eye_phase_ff <= REG_WDATA[5:0];
			if (REG_ADDR == `EQRC_REG_EYE_VOLT)
				eye_volt_ff <= REG_WDATA[5:0];
		end
	end

	// ****************************************
	// Strap decode of adaptation
	// ****************************************
	// Strap table.
	wire low_rate = rate == `EQRC_RATE_1G5 || rate == `EQRC_RATE_270M;
	wire strap_auto = host_lvl == eqrc_pkg::LVL_F && !low_rate;
	wire [7:0] strap_boost = host_lvl == eqrc_pkg::LVL_R ? `EQRC_BOOST_R :
		host_lvl == eqrc_pkg::LVL_L ? `EQRC_BOOST_L :
		host_lvl == eqrc_pkg::LVL_F ? `EQRC_BOOST_F : `EQRC_BOOST_H;

	// ****************************************
	// Path decode
	// ****************************************
	// Equalizer mode bypass.
	wire eq_line_on = byp_lvl == eqrc_pkg::LVL_F || byp_lvl == eqrc_pkg::LVL_L;
	wire eq_reclk_on = byp_lvl == eqrc_pkg::LVL_F || byp_lvl == eqrc_pkg::LVL_H;
	wire cd_reclk_on = byp_lvl == eqrc_pkg::LVL_H || byp_lvl == eqrc_pkg::LVL_F;
	wire strap_reclk = cd_mode ? cd_reclk_on : eq_reclk_on;
	wire byp_ovr = byp_ctrl_ff[`EQRC_BYP_OVR_EN];
	wire path_line = byp_ovr ? !byp_ctrl_ff[`EQRC_BYP_OVR_LINE] : eq_line_on;
	wire path_reclk = byp_ovr ? !byp_ctrl_ff[`EQRC_BYP_OVR_RECLK] : strap_reclk;
	wire sel_auto = adapt_ctrl_ff[`EQRC_ADAPT_OVR_EN] ? adapt_ctrl_ff[`EQRC_ADAPT_OVR_AUTO] :
		strap_auto;
	wire [7:0] sel_boost = adapt_ctrl_ff[`EQRC_BOOST_OVR_EN] ? boost_ovr_ff : strap_boost;

	// Supported rates, sub-rates on the top four.
	wire top_rate = rate == `EQRC_RATE_12G || rate == `EQRC_RATE_6G ||
		rate == `EQRC_RATE_3G || rate == `EQRC_RATE_1G5;
	wire rate_reclk = rate == `EQRC_RATE_NONE || top_rate || (rate == `EQRC_RATE_270M && !frac);
	// Manual forced whenever the driver path runs without reclocker.
	wire force_manual = cd_mode && !(path_reclk && rate_reclk);
	wire eye_rate_ok = rate == `EQRC_RATE_12G || rate == `EQRC_RATE_6G || rate == `EQRC_RATE_3G;

	eqrc_pkg::eqrc_path_t nxt_path;
	eqrc_pkg::eqrc_adapt_t nxt_adapt;
	// Driver mode powers the host equalizer, drops the line one.
	assign nxt_path.line_eq_en = !cd_mode && path_line;
	assign nxt_path.host_eq_en = cd_mode;
	assign nxt_path.reclk_en = path_reclk && rate_reclk;
	// Host settings held neutral in equalizer mode.
	assign nxt_adapt.auto_mode = cd_mode && sel_auto && !force_manual;
	assign nxt_adapt.boost = cd_mode ? sel_boost : 8'h00;

	// ****************************************
	// Mode change recovery reset
	// ****************************************
	logic [7:0] cdr_cnt_ff;
	wire mode_chg = mode2_ff != mode_prev_ff;

	// Reset the loop on every mode flip.
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			cdr_cnt_ff <= 8'h00;
		else if (mode_chg)
			cdr_cnt_ff <= 8'(CDR_RST_CYC);
		else if (cdr_cnt_ff != 8'h00)
			cdr_cnt_ff <= cdr_cnt_ff - 8'h01;
	end

	// ****************************************
	// Eye monitor
	// ****************************************
	// The count memory is cleared by a sweep, so a start costs one pass before hits are taken.
	eqrc_pkg::eqrc_eye_st_t eye_st_ff, nxt_eye_st;
	logic [AW-1:0] clr_ff;
	logic [CNT_W-1:0] hit_mem [0:DEPTH-1];
	logic [CNT_W-1:0] cnt_rd_ff;

	wire [AW-1:0] hit_addr = {EYE_VOLT, EYE_PHASE};
	wire [AW-1:0] rd_addr = {eye_volt_ff, eye_phase_ff};
	wire [CNT_W-1:0] hit_cur = hit_mem[hit_addr];
	wire hit_take = eye_st_ff == eqrc_pkg::EYE_RUN && eye_rate_ok && EYE_HIT;
	wire clr_last = clr_ff == AW'(DEPTH - 1);

	always_comb
	begin
		nxt_eye_st = eye_st_ff;
		unique case (eye_st_ff)
			eqrc_pkg::EYE_IDLE:
				if (eye_start)
					nxt_eye_st = eqrc_pkg::EYE_CLEAR;
			eqrc_pkg::EYE_CLEAR:
				if (eye_stop)
					nxt_eye_st = eqrc_pkg::EYE_IDLE;
				else if (clr_last)
					nxt_eye_st = eqrc_pkg::EYE_RUN;
			eqrc_pkg::EYE_RUN:
				if (eye_stop || EYE_DONE)
					nxt_eye_st = eqrc_pkg::EYE_IDLE;
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			eye_st_ff <= eqrc_pkg::EYE_IDLE;
			clr_ff <= '0;
		end
		else
		begin
			eye_st_ff <= nxt_eye_st;
			clr_ff <= eye_st_ff == eqrc_pkg::EYE_CLEAR ? clr_ff + AW'(1) : '0;
		end
	end

	// Saturating hit accumulation per phase and voltage step.
	always_ff @(posedge CLK)
	begin
		if (eye_st_ff == eqrc_pkg::EYE_CLEAR)
			hit_mem[clr_ff] <= '0;
		else if (hit_take && hit_cur != '1)
			hit_mem[hit_addr] <= hit_cur + CNT_W'(1);
	end

	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			cnt_rd_ff <= '0;
		else
			cnt_rd_ff <= hit_mem[rd_addr];
	end

	// Latch the openings at the end of a capture.
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			hopen_ff <= 8'h00;
			vopen_ff <= 8'h00;
		end
		else if (EYE_DONE && eye_st_ff == eqrc_pkg::EYE_RUN)
		begin
			hopen_ff <= EYE_HOPEN;
			vopen_ff <= EYE_VOPEN;
		end
	end

	// ****************************************
	// Read back
	// ****************************************
	logic [7:0] rd_mux;
	always_comb
	begin
		rd_mux = `EQRC_UNMAPPED;
		if (preset_hit)
			rd_mux = preset_ff[preset_wi];
		else
			unique case (REG_ADDR)
				`EQRC_REG_ADAPT_CTRL: rd_mux = {5'h00, adapt_ctrl_ff};
				`EQRC_REG_BOOST_OVR: rd_mux = boost_ovr_ff;
				`EQRC_REG_BYPASS_CTRL: rd_mux = {5'h00, byp_ctrl_ff};
				`EQRC_REG_STATUS: rd_mux = {2'h0, EYE_EN, ADAPT_AUTO, RECLK_EN,
					HOST_EQ_EN, LINE_EQ_EN, cd_mode};
				`EQRC_REG_BOOST_NOW: rd_mux = BOOST;
				`EQRC_REG_EYE_PHASE: rd_mux = {2'h0, eye_phase_ff};
				`EQRC_REG_EYE_VOLT: rd_mux = {2'h0, eye_volt_ff};
				`EQRC_REG_EYE_CNT_LO: rd_mux = cnt_rd_ff[7:0];
				`EQRC_REG_EYE_CNT_HI: rd_mux = cnt_rd_ff[15:8];
				`EQRC_REG_HOPEN: rd_mux = hopen_ff;
				`EQRC_REG_VOPEN: rd_mux = vopen_ff;
				`EQRC_REG_EYE_STAT: rd_mux = {6'h00, eye_st_ff == eqrc_pkg::EYE_RUN,
					eye_st_ff == eqrc_pkg::EYE_CLEAR};
				default: rd_mux = `EQRC_UNMAPPED;
			endcase
	end

	// ****************************************
	// Output flops
	// ****************************************
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			LINE_EQ_EN <= 1'b0;
			HOST_EQ_EN <= 1'b0;
			RECLK_EN <= 1'b0;
			ADAPT_AUTO <= 1'b0;
			BOOST <= 8'h00;
			CDR_RESET <= 1'b1;
			EYE_EN <= 1'b0;
			PRESET_VAL <= 8'h00;
			REG_RDATA <= 8'h00;
			REG_RVALID <= 1'b0;
		end
		else
		begin
			LINE_EQ_EN <= nxt_path.line_eq_en;
			HOST_EQ_EN <= nxt_path.host_eq_en;
			RECLK_EN <= nxt_path.reclk_en;
			ADAPT_AUTO <= nxt_adapt.auto_mode;
			BOOST <= nxt_adapt.boost;
			CDR_RESET <= mode_chg || cdr_cnt_ff > 8'h01;
			EYE_EN <= eye_st_ff == eqrc_pkg::EYE_RUN && eye_rate_ok;
			PRESET_VAL <= preset_ff[PRESET_IDX];
			REG_RDATA <= REG_RD ? rd_mux : REG_RDATA;
			REG_RVALID <= REG_RD;
		end
	end

endmodule

// ===== tb/eqrc_strap_model.sv
`timescale 1ns/1ps
module eqrc_strap_model (
	// Clock
	input wire logic clk,
	// Requested levels and hits
	input eqrc_pkg::eqrc_lvl_t host_lvl,
	input eqrc_pkg::eqrc_lvl_t byp_lvl,
	input wire logic [3:0] hit_req,
	input wire logic [11:0] hit_at,
	// Pads and sampler
	output logic [1:0] host_code,
	output logic [1:0] byp_code,
	output logic eye_hit,
	output logic [5:0] eye_phase,
	output logic [5:0] eye_volt
);
	logic [3:0] sent_ff = 4'h0;
	logic hit_ff = 1'b0;
	logic [11:0] at_ff = 12'h0;
	assign host_code = 2'(host_lvl);
	assign byp_code = 2'(byp_lvl);
	assign eye_hit = hit_ff;
	assign {eye_volt, eye_phase} = at_ff;
	// Idle address toggles so a stale point never looks like a hit.
	always_ff @(posedge clk)
	begin
		hit_ff <= sent_ff != hit_req;
		at_ff <= (sent_ff != hit_req) ? hit_at : ~at_ff;
		if (sent_ff != hit_req)
			sent_ff <= sent_ff + 4'h1;
	end
endmodule

// ===== tb/eqrc_ctrl_properties.sv
`timescale 1ns/1ps
module eqrc_ctrl_properties (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Inputs seen
	input wire logic MODE_SELECT_PIN,
	input wire logic [1:0] HOST_BOOST_STRAP,
	input wire logic [1:0] BYPASS_STRAP,
	input wire logic [2:0] RATE_CODE,
	input wire logic REG_RD,
	// Outputs seen
	input wire logic REG_RVALID,
	input wire logic LINE_EQ_EN,
	input wire logic HOST_EQ_EN,
	input wire logic RECLK_EN,
	input wire logic ADAPT_AUTO,
	input wire logic [7:0] BOOST,
	input wire logic CDR_RESET,
	input wire logic EYE_EN
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	// A second mode flip within the hold would stretch it; the bench spaces flips apart.
	sequence cdr_held;
		CDR_RESET [*8] ##8 CDR_RESET ##1 !CDR_RESET;
	endsequence
	a_drv_path_on: assert property (MODE_SELECT_PIN [*5]
		|-> HOST_EQ_EN && !LINE_EQ_EN)
		else $error("driver mode path wrong");
	a_eq_host_off: assert property (!MODE_SELECT_PIN [*5]
		|-> !HOST_EQ_EN && BOOST == 8'h00 && !ADAPT_AUTO)
		else $error("host equalizer active in equalizer mode");
	a_auto_needs_reclk: assert property (ADAPT_AUTO |-> RECLK_EN && HOST_EQ_EN)
		else $error("adaptive mode without reclocker");
	a_strap_r_boost: assert property ((MODE_SELECT_PIN && HOST_BOOST_STRAP == 2'h1) [*5]
		|-> !ADAPT_AUTO && BOOST == 8'h80)
		else $error("strap R boost wrong");
	a_eq_byp_both: assert property ((!MODE_SELECT_PIN && BYPASS_STRAP == 2'h1) [*5]
		|-> !LINE_EQ_EN && !RECLK_EN)
		else $error("bypass R not honoured");
	a_slow_rate_byp: assert property ((RATE_CODE == 3'h6) [*4] |-> !RECLK_EN)
		else $error("reclocker on at slow rate");
	a_eye_rate_gate: assert property ((RATE_CODE inside {3'h4, 3'h5, 3'h6}) [*4]
		|-> !EYE_EN)
		else $error("eye monitor on at low rate");
	a_read_answer: assert property (REG_RD |=> REG_RVALID)
		else $error("read not answered");
	a_read_quiet: assert property (!REG_RD |=> !REG_RVALID)
		else $error("spurious read valid");
	a_cdr_on_flip: assert property ($changed(MODE_SELECT_PIN) |-> ##[1:5] CDR_RESET)
		else $error("no loop reset on mode change");
	a_cdr_hold_len: assert property ($rose(CDR_RESET) |-> cdr_held)
		else $error("loop reset length wrong");
endmodule
bind eqrc_ctrl eqrc_ctrl_properties i_eqrc_ctrl_properties (.CLK(CLK), .RST_N(RST_N),
	.MODE_SELECT_PIN(MODE_SELECT_PIN), .HOST_BOOST_STRAP(HOST_BOOST_STRAP),
	.BYPASS_STRAP(BYPASS_STRAP), .RATE_CODE(RATE_CODE), .REG_RD(REG_RD),
	.REG_RVALID(REG_RVALID), .LINE_EQ_EN(LINE_EQ_EN), .HOST_EQ_EN(HOST_EQ_EN),
	.RECLK_EN(RECLK_EN), .ADAPT_AUTO(ADAPT_AUTO), .BOOST(BOOST), .CDR_RESET(CDR_RESET),
	.EYE_EN(EYE_EN));

// ===== tb/tb_eqrc_ctrl.sv
`timescale 1ns/1ps
module tb_eqrc_ctrl;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic MODE_SELECT_PIN = 1'b1;
	eqrc_pkg::eqrc_lvl_t host_lvl = eqrc_pkg::LVL_F;
	eqrc_pkg::eqrc_lvl_t byp_lvl = eqrc_pkg::LVL_F;
	logic [1:0] HOST_BOOST_STRAP, BYPASS_STRAP;
	logic [2:0] RATE_CODE = 3'h1;
	logic RATE_FRAC = 1'b0;
	logic [3:0] PRESET_IDX = 4'h0;
	logic [3:0] hit_req = 4'h0;
	logic [7:0] PRESET_VAL, REG_RDATA, BOOST;
	logic [7:0] EYE_HOPEN = 8'h2a;
	logic [7:0] EYE_VOPEN = 8'h15;
	logic EYE_HIT, REG_RVALID, LINE_EQ_EN, HOST_EQ_EN, RECLK_EN, ADAPT_AUTO, CDR_RESET, EYE_EN;
	logic EYE_DONE = 1'b0;
	logic REG_WR = 1'b0;
	logic REG_RD = 1'b0;
	logic [5:0] EYE_PHASE, EYE_VOLT;
	logic [7:0] REG_ADDR = 8'h00;
	logic [7:0] REG_WDATA = 8'h00;
	logic [2:0] rates [4] = '{3'h1, 3'h4, 3'h5, 3'h6};
	int fail_count = 0;
	int checks_done = 0;
	eqrc_strap_model i_eqrc_strap_model (.clk(CLK), .host_lvl(host_lvl), .byp_lvl(byp_lvl),
		.hit_req(hit_req), .hit_at(12'h1c5), .host_code(HOST_BOOST_STRAP),
		.byp_code(BYPASS_STRAP), .eye_hit(EYE_HIT), .eye_phase(EYE_PHASE), .eye_volt(EYE_VOLT));
	eqrc_ctrl i_eqrc_ctrl (.CLK(CLK), .RST_N(RST_N), .MODE_SELECT_PIN(MODE_SELECT_PIN),
		.HOST_BOOST_STRAP(HOST_BOOST_STRAP), .BYPASS_STRAP(BYPASS_STRAP),
		.RATE_CODE(RATE_CODE), .RATE_FRAC(RATE_FRAC), .PRESET_IDX(PRESET_IDX),
		.PRESET_VAL(PRESET_VAL), .EYE_HIT(EYE_HIT), .EYE_PHASE(EYE_PHASE),
		.EYE_VOLT(EYE_VOLT), .EYE_DONE(EYE_DONE), .EYE_HOPEN(EYE_HOPEN), .EYE_VOPEN(EYE_VOPEN),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .LINE_EQ_EN(LINE_EQ_EN),
		.HOST_EQ_EN(HOST_EQ_EN), .RECLK_EN(RECLK_EN), .ADAPT_AUTO(ADAPT_AUTO),
		.BOOST(BOOST), .CDR_RESET(CDR_RESET), .EYE_EN(EYE_EN));
	initial
	begin
		forever #2 CLK = ~CLK;
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge CLK);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= v;
		@(posedge CLK);
		REG_WR <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge CLK);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge CLK);
		REG_RD <= 1'b0;
		#1;
		chk("rvalid", REG_RVALID, 1'b1);
		chk(what, REG_RDATA, exp);
	endtask
	// Boost is left open while adapting, so it is masked out then.
	function automatic logic [11:0] exp_path(input logic m, input logic [1:0] h, b,
		input logic [2:0] r);
		logic rk;
		logic au;
		logic [7:0] bo;
		rk = (b == 2'h3 || b == 2'h2) && r != 3'h6;
		au = m && rk && h == 2'h2 && r inside {3'h1, 3'h2, 3'h3};
		bo = (h == 2'h1) ? 8'h80 : (h == 2'h0) ? 8'h90 : 8'h00;
		return {!m && (b == 2'h2 || b == 2'h0), m, rk, au, (m && !au) ? bo : 8'h00};
	endfunction
	task automatic path_set(input logic [1:0] h, input logic [1:0] b, input logic [2:0] r);
		logic [11:0] e;
		@(posedge CLK);
		host_lvl <= eqrc_pkg::eqrc_lvl_t'(h);
		byp_lvl <= eqrc_pkg::eqrc_lvl_t'(b);
		RATE_CODE <= r;
		RATE_FRAC <= r == 3'h1 || r == 3'h4;
		cyc(6);
		e = exp_path(MODE_SELECT_PIN, h, b, r);
		chk("line_eq", LINE_EQ_EN, e[11]);
		chk("host_eq", HOST_EQ_EN, e[10]);
		chk("reclk", RECLK_EN, e[9]);
		chk("adapt", ADAPT_AUTO, e[8]);
		chk("boost", e[8] ? 8'h00 : BOOST, e[7:0]);
	endtask
	initial
	begin
		#100000;
		fail_count++;
		end_sim();
	end
	initial
	begin
		cyc(5);
		chk("reset", {CDR_RESET, LINE_EQ_EN, HOST_EQ_EN, RECLK_EN, REG_RVALID}, 12'h10);
		@(posedge CLK);
		RST_N <= 1'b1;
		rd_chk(8'h47, 8'h00, "preset7");
		reg_wr(8'h40, 8'ha5);
		reg_wr(8'h4f, 8'h5a);
		reg_wr(8'h30, 8'hff);
		rd_chk(8'h40, 8'ha5, "preset0");
		rd_chk(8'h4f, 8'h5a, "preset15");
		rd_chk(8'h30, 8'h00, "unmapped");
		@(posedge CLK);
		PRESET_IDX <= 4'hf;
		cyc(2);
		chk("preset_val", PRESET_VAL, 8'h5a);
		for (int m = 0; m < 2; m++)
		begin
			@(posedge CLK);
			MODE_SELECT_PIN <= m[0];
			cyc(5);
			chk("cdr_on", CDR_RESET, 1'b1);
			cyc(25);
			chk("cdr_off", CDR_RESET, 1'b0);
			for (int k = 0; k < 64; k++)
				path_set(k[5:4], k[3:2], rates[k[1:0]]);
		end
		path_set(2'h0, 2'h2, 3'h1);
		reg_wr(8'h00, 8'h05);
		reg_wr(8'h01, 8'h33);
		cyc(2);
		chk("boost_ovr", {ADAPT_AUTO, BOOST}, 12'h033);
		rd_chk(8'h04, 8'h33, "boost_reg");
		rd_chk(8'h03, 8'h0d, "status");
		reg_wr(8'h00, 8'h03);
		cyc(2);
		chk("auto_ovr", ADAPT_AUTO, 1'b1);
		reg_wr(8'h02, 8'h05);
		cyc(2);
		chk("byp_ovr", {RECLK_EN, ADAPT_AUTO}, 12'h0);
		reg_wr(8'h00, 8'h00);
		reg_wr(8'h02, 8'h00);
		reg_wr(8'h10, 8'h01);
		cyc(4100);
		chk("eye_run", EYE_EN, 1'b1);
		@(posedge CLK);
		hit_req <= 4'h3;
		cyc(8);
		rd_chk(8'h15, 8'h00, "hopen_early");
		rd_chk(8'h17, 8'h02, "eye_stat_run");
		@(posedge CLK);
		EYE_DONE <= 1'b1;
		@(posedge CLK);
		EYE_DONE <= 1'b0;
		EYE_HOPEN <= 8'h00;
		EYE_VOPEN <= 8'h00;
		cyc(2);
		chk("eye_idle", EYE_EN, 1'b0);
		reg_wr(8'h11, 8'h05);
		reg_wr(8'h12, 8'h07);
		cyc(3);
		rd_chk(8'h13, 8'h03, "hits_lo");
		rd_chk(8'h14, 8'h00, "hits_hi");
		rd_chk(8'h15, 8'h2a, "hopen");
		rd_chk(8'h16, 8'h15, "vopen");
		reg_wr(8'h10, 8'h01);
		rd_chk(8'h17, 8'h01, "eye_stat_clear");
		reg_wr(8'h10, 8'h02);
		rd_chk(8'h17, 8'h00, "eye_stat_stop");
		end_sim();
	end
endmodule
